// >>> src/pfs_port_func.v
// Per-port function selection and digital routing with APB registers
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "pfs_defs.vh"
module pfs_port_func #(
  parameter NPORTS = 12,
  parameter CODE_W = 12
) (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  input wire clk_en,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Threshold input values from the port comparators
  input wire [NPORTS-1:0] threshold_digital_input,
  // Converter result strobe and data
  input wire adc_result_valid,
  input wire [3:0] adc_result_port,
  input wire [CODE_W-1:0] adc_result_data,
  // Port drivers
  output reg [NPORTS-1:0] digital_out_en,
  output reg [NPORTS-1:0] digital_out_value,
  output reg [NPORTS-1:0] analog_out_en,
  output reg [NPORTS-1:0] adc_sample_en,
  output reg [NPORTS*CODE_W-1:0] dac_code
);
  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  reg [15:0] port_cfg [0:NPORTS-1];
  reg [CODE_W-1:0] port_code [0:NPORTS-1];
  reg [NPORTS-1:0] output_level_bits;
  wire [CODE_W-1:0] result_rd;
  reg rd_pending;
  // Ports in monitored analog mode, gates result writes
  wire [NPORTS-1:0] mon_mode;

  wire apb_setup = psel && !penable;
  wire apb_access = psel && penable;
  wire [11:0] off = paddr & 12'hFFC;
  wire [3:0] idx = off[5:2];
  wire idx_ok = (idx < NPORTS);
  wire in_cfg = ({off[11:6], 6'h00} == `PFS_REG_CFG_BASE) && idx_ok;
  wire in_code = ({off[11:6], 6'h00} == `PFS_REG_CODE_BASE) && idx_ok;
  wire in_res = ({off[11:6], 6'h00} == `PFS_REG_RESULT_BASE) && idx_ok;
  wire is_lvl = (off == `PFS_REG_LEVELS);
  wire is_inp = (off == `PFS_REG_INPUTS);
  wire mapped = in_cfg || in_code || in_res || is_lvl || is_inp;
  wire wr_fire = apb_access && pready && pwrite;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion result memory
  pfs_word_mem #(
    .WIDTH(CODE_W),
    .DEPTH(NPORTS),
    .AW(4)
  ) u_result_mem (
    .core_clk(core_clk),
    .clk_en(clk_en),
    .wr_en(adc_result_valid && (adc_result_port < NPORTS) && mon_mode[adc_result_port]),
    .wr_addr(adc_result_port),
    .wr_data(adc_result_data),
    .rd_addr(idx),
    .rd_data(result_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state so result memory read settles
  integer i;
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      for (i = 0; i < NPORTS; i = i + 1)
      begin
        port_cfg[i] <= `PFS_CFG_RESET;
        port_code[i] <= `PFS_CODE_RESET;
      end
      output_level_bits <= {NPORTS{1'b0}};
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      rd_pending <= 1'b0;
    end
    else if (clk_en)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      // Result memory is addressed during setup, data stands at access
      if (apb_setup)
      begin
        rd_pending <= 1'b1;
      end
      else if (apb_access && rd_pending && !pready)
      begin
        rd_pending <= 1'b0;
        pready <= 1'b1;
        pslverr <= !mapped;
        prdata <= 32'h0000_0000;
        if (!pwrite)
        begin
          if (in_cfg)
            prdata <= {16'h0000, port_cfg[idx]};
          else if (in_code)
            prdata <= {{(32-CODE_W){1'b0}}, port_code[idx]};
          else if (in_res)
            prdata <= {{(32-CODE_W){1'b0}}, result_rd};
          else if (is_lvl)
            prdata <= {{(32-NPORTS){1'b0}}, output_level_bits};
          else if (is_inp)
            prdata <= {{(32-NPORTS){1'b0}}, threshold_digital_input};
        end
      end
      if (wr_fire)
      begin
        if (in_cfg)
          port_cfg[idx] <= pwdata[15:0];
        else if (in_code)
          port_code[idx] <= pwdata[CODE_W-1:0];
        else if (is_lvl)
          output_level_bits <= pwdata[NPORTS-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-port mode decode and routing
  wire [NPORTS-1:0] next_dig_en;
  wire [NPORTS-1:0] next_dig_val;
  wire [NPORTS-1:0] next_ana_en;
  wire [NPORTS-1:0] next_adc_en;
  wire [NPORTS*CODE_W-1:0] next_dac;

  genvar g;
  generate
    for (g = 0; g < NPORTS; g = g + 1)
    begin : g_port
      wire [3:0] port_function_code = port_cfg[g][`PFS_CFG_FC_HI:`PFS_CFG_FC_LO];
      wire invert_forwarded_value = port_cfg[g][`PFS_CFG_INV_BIT];
      wire [2:0] range = port_cfg[g][`PFS_CFG_RANGE_HI:`PFS_CFG_RANGE_LO];
      wire [3:0] assoc = port_cfg[g][`PFS_CFG_ASSOC_HI:`PFS_CFG_ASSOC_LO];
      wire is_lvl_out = (port_function_code == `PFS_FC_LVL_OUT);
      wire is_xlat = (port_function_code == `PFS_FC_XLAT_OUT);
      wire is_ana = (port_function_code == `PFS_FC_ANA_OUT);
      wire is_mon = (port_function_code == `PFS_FC_ANA_MON);
      // Each port indexes the shared input vector on its own
      wire src_val = (assoc < NPORTS) ? threshold_digital_input[assoc] : 1'b0;
      wire clip = is_mon && (range == `PFS_RANGE_LOW_BAND) && (port_code[g] > `PFS_CLIP_MAX_CODE);
      assign mon_mode[g] = is_mon;
      assign next_dig_en[g] = is_lvl_out || is_xlat;
      assign next_dig_val[g] = is_lvl_out ? output_level_bits[g] :
                               is_xlat ? (src_val ^ invert_forwarded_value) : 1'b0;
      assign next_ana_en[g] = is_ana || is_mon;
      assign next_adc_en[g] = is_mon;
      // Driver code: logic-one level or analog voltage; zero when high impedance
      assign next_dac[g*CODE_W +: CODE_W] = clip ? `PFS_CLIP_MAX_CODE :
        (is_lvl_out || is_xlat || is_ana || is_mon) ? port_code[g] : `PFS_CODE_RESET;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Registered driver outputs
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      digital_out_en <= {NPORTS{1'b0}};
      digital_out_value <= {NPORTS{1'b0}};
      analog_out_en <= {NPORTS{1'b0}};
      adc_sample_en <= {NPORTS{1'b0}};
      dac_code <= {(NPORTS*CODE_W){1'b0}};
    end
    else if (clk_en)
    begin
      digital_out_en <= next_dig_en;
      digital_out_value <= next_dig_val;
      analog_out_en <= next_ana_en;
      adc_sample_en <= next_adc_en;
      dac_code <= next_dac;
    end
  end
endmodule
`default_nettype wire

// >>> src/pfs_defs.vh
// Constants for the port function select block
`ifndef PFS_DEFS_VH
`define PFS_DEFS_VH
// Function codes
`define PFS_FC_HIZ 4'h0
`define PFS_FC_LVL_OUT 4'h3
`define PFS_FC_XLAT_OUT 4'h4
`define PFS_FC_ANA_OUT 4'h5
`define PFS_FC_ANA_MON 4'h6
// Configuration word fields
`define PFS_CFG_FC_HI 15
`define PFS_CFG_FC_LO 12
`define PFS_CFG_INV_BIT 11
`define PFS_CFG_RANGE_HI 10
`define PFS_CFG_RANGE_LO 8
`define PFS_CFG_ASSOC_HI 3
`define PFS_CFG_ASSOC_LO 0
`define PFS_RANGE_LOW_BAND 3'h4
// Register byte offsets
`define PFS_REG_CFG_BASE 12'h000
`define PFS_REG_CODE_BASE 12'h040
`define PFS_REG_RESULT_BASE 12'h080
`define PFS_REG_LEVELS 12'h0C0
`define PFS_REG_INPUTS 12'h0C4
// Reset values and clip limit code
`define PFS_CFG_RESET 16'h0000
`define PFS_CODE_RESET 12'h000
`define PFS_CLIP_MAX_CODE 12'h7FF
`endif

// >>> src/pfs_word_mem.v
// Small register-file memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module pfs_word_mem #(
  parameter WIDTH = 12,
  parameter DEPTH = 12,
  parameter AW = 4
) (
  // Clock
  input wire core_clk,
  input wire clk_en,
  // Write side
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  // Read side
  input wire [AW-1:0] rd_addr,
  output reg [WIDTH-1:0] rd_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge core_clk)
  begin
    if (clk_en)
    begin
      if (wr_en)
        mem[wr_addr] <= wr_data;
      rd_data <= mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

// >>> bench/pfs_chk.sv
// Port checks for the port function select block
`timescale 1ns/10ps
`default_nettype none
module pfs_chk #(
  parameter NPORTS = 12,
  parameter CODE_W = 12
) (
  // APB
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  // Drivers
  input wire logic [NPORTS-1:0] digital_out_en,
  input wire logic [NPORTS-1:0] analog_out_en,
  input wire logic [NPORTS-1:0] adc_sample_en,
  input wire logic [NPORTS*CODE_W-1:0] dac_code
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic idle_ok;
  always_comb
  begin
    idle_ok = 1'b1;
    for (int i = 0; i < NPORTS; i++)
      if (!digital_out_en[i] && !analog_out_en[i] && dac_code[i*CODE_W +: CODE_W] != '0)
        idle_ok = 1'b0;
  end
  sequence s_req; psel && !penable ##1 psel && penable; endsequence
  property p_answer; s_req |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("no answer after one wait");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready too long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_cause; $rose(pready) |-> $past(psel && penable); endproperty
  a_cause: assert property (p_cause) else $error("ready without access");
  property p_mon; (adc_sample_en & ~analog_out_en) == '0; endproperty
  a_mon: assert property (p_mon) else $error("sampled port not driven");
  property p_excl; (digital_out_en & analog_out_en) == '0; endproperty
  a_excl: assert property (p_excl) else $error("two modes at once");
  property p_idle; idle_ok; endproperty
  a_idle: assert property (p_idle) else $error("code on idle port");
  property p_late;
    $changed({digital_out_en, analog_out_en, adc_sample_en, dac_code}) |->
      $past(pwrite && pready) || $past(pwrite && pready, 2) || $past(pwrite && pready, 3);
  endproperty
  a_late: assert property (p_late) else $error("drivers changed without write");
endmodule
bind pfs_port_func pfs_chk #(.NPORTS(NPORTS), .CODE_W(CODE_W)) i_chk (.*);
`default_nettype wire

// >>> bench/pfs_host.sv
// Host model issuing APB transfers
`timescale 1ns/10ps
`default_nettype none
module pfs_host (
  // Clock
  input wire logic core_clk,
  // APB master
  output var logic psel,
  output var logic penable,
  output var logic pwrite,
  output var logic [11:0] paddr,
  output var logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic [31:0] q;
  logic e;
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
  end
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd, output logic er);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Code first, then high impedance, then the new function
  task automatic set_port(input logic [3:0] p, input logic [11:0] c, input logic [15:0] cfg);
    xfer(1'b1, {6'h01, p, 2'b00}, {20'h0_0000, c}, q, e);
    xfer(1'b1, {6'h00, p, 2'b00}, '0, q, e);
    xfer(1'b1, {6'h00, p, 2'b00}, {16'h0000, cfg}, q, e);
  endtask
endmodule
`default_nettype wire

// >>> bench/tb.sv
// Self-checking bench for the port function select block
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, e, avld = 1'b0;
  logic [11:0] paddr, den, dval, aen, sen, thr = '0, adata = '0, lvl = '0;
  logic [3:0] aport = '0;
  logic [31:0] pwdata, prdata, q;
  logic [143:0] dac;
  logic [15:0] cfg [12];
  logic [11:0] code [12], res [12];
  int fails = 0, tests_run = 0, seed = 32'he2d4_8adb;
  always #50 core_clk = ~core_clk;
  pfs_port_func i_dut (.*, .clk_en(1'b1), .threshold_digital_input(thr), .adc_result_valid(avld),
    .adc_result_port(aport), .adc_result_data(adata), .digital_out_en(den), .digital_out_value(dval),
    .analog_out_en(aen), .adc_sample_en(sen), .dac_code(dac));
  pfs_host i_host (.*);
  task automatic chk(input string n, input logic [143:0] s, input logic [143:0] x);
    tests_run++;
    if (s !== x)
    begin
      fails++;
      $display("MISMATCH %s exp %h got %h", n, x, s);
    end
  endtask
  task automatic end_sim;
    $display("Checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Expected drivers from the model
  task automatic outs;
    logic [11:0] xd, xv, xa, xs, c;
    logic [143:0] xc;
    logic [3:0] f;
    for (int i = 0; i < 12; i++)
    begin
      f = cfg[i][15:12];
      c = (f == 4'h6 && cfg[i][10:8] == 3'h4 && code[i] > 12'h7ff) ? 12'h7ff : code[i];
      xd[i] = f == 4'h3 || f == 4'h4;
      xv[i] = f == 4'h3 ? lvl[i] : (cfg[i][3:0] < 12 ? thr[cfg[i][3:0]] : 1'b0) ^ cfg[i][11];
      xa[i] = f == 4'h5 || f == 4'h6;
      xs[i] = f == 4'h6;
      xc[i*12 +: 12] = (xd[i] || xa[i]) ? c : 12'h000;
    end
    chk("den", den, xd);
    chk("dval", dval & den, xv & xd);
    chk("aen", aen, xa);
    chk("sen", sen, xs);
    chk("dac", dac, xc);
  endtask
  ////////////////////////////////////////
  initial
  begin
    logic [3:0] p, f, s;
    logic [31:0] w, r;
    logic [15:0] cf;
    for (int i = 0; i < 12; i++)
    begin
      cfg[i] = '0;
      code[i] = '0;
      res[i] = '0;
    end
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    for (int n = 0; n < 40; n++)
    begin
      w = $random(seed);
      r = $random(seed);
      p = w[31:28] % 4'd12;
      f = w[26:24] % 3'd5;
      if (f != 4'h0) f = f + 4'h2;
      s = w[3:0];
      cf = {f, w[11], w[4] ? 3'h4 : w[10:8], 4'h0, s};
      if (f == 4'h4 && s < 12 && s != p)
      begin
        i_host.set_port(s, code[s], 16'h1000);
        cfg[s] = 16'h1000;
      end
      code[p] = r[11:0];
      cfg[p] = cf;
      i_host.set_port(p, r[11:0], cf);
      i_host.xfer(1'b1, 12'h0c0, {20'h0_0000, r[23:12]}, q, e);
      lvl = r[23:12];
      thr <= w[27:16];
      repeat (3) @(posedge core_clk);
      outs;
      i_host.xfer(1'b0, {6'h00, p, 2'b00}, '0, q, e);
      chk("cfg", q, cf);
      aport <= p;
      adata <= r[31:20];
      avld <= 1'b1;
      @(posedge core_clk);
      avld <= 1'b0;
      if (f == 4'h6) res[p] = r[31:20];
      i_host.xfer(1'b0, {6'h02, p, 2'b00}, '0, q, e);
      chk("res", q, res[p]);
    end
    i_host.xfer(1'b0, 12'h0c8, '0, q, e);
    chk("err", e, 1'b1);
    chk("rdata", q, '0);
    end_sim;
  end
  initial
  begin
    #2_000_000;
    fails++;
    end_sim;
  end
endmodule
`default_nettype wire
